// ===== pkg/capability_defines.vh
/*
  Constants for the device capability register bank: byte offsets,
  capability field codes, bit positions and the clock gating pass mask.
  Assumes it is included once per design file by its bare name.
*/
`ifndef CAPABILITY_DEFINES_VH
`define CAPABILITY_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define MEMORY_SIZE_CAPS_OFFSET 12'h004
`define CORE_FEATURE_CAPS_OFFSET 12'h010
`define PERIPHERAL_PRESENCE_CAPS_OFFSET 12'h014

// ****************************************
// Memory size word
// ****************************************
`define RAM_SIZE_CODE 16'h001f
`define PROGRAM_MEMORY_SIZE_CODE 16'h001f

// ****************************************
// Core feature word fields
// ****************************************
`define MIN_SYSTEM_DIVIDER 4'h3
`define MAX_SAMPLE_RATE_CODE 4'h3
`define RATE_LSB 8
`define RATE_MSB 11
`define DIVIDER_LSB 12
`define DIVIDER_MSB 15
`define BIT_PWM 20
`define BIT_ADC 16
`define BIT_PROTECTION_UNIT 7
`define BIT_TEMP_SENSOR 5
`define BIT_SYNTHESIZER 4
`define BIT_WATCHDOG 3
`define BIT_TRACE_OUTPUT 2
`define BIT_TWO_WIRE_DEBUG 1
`define BIT_BOUNDARY_SCAN 0

// ****************************************
// Peripheral presence word fields
// ****************************************
`define BIT_COMPARATOR_ZERO 24
`define BIT_TIMER_TWO 18
`define BIT_TIMER_ONE 17
`define BIT_TIMER_ZERO 16
`define BIT_QUADRATURE_DECODER 8
`define BIT_SYNC_SERIAL 4
`define BIT_ASYNC_SERIAL_ONE 1
`define BIT_ASYNC_SERIAL_ZERO 0

// ****************************************
// Clock gating pass mask (single bits that follow a capability bit)
// ****************************************
`define GATE_SINGLE_BIT_MASK 32'h0011000f
`define WORD_ZERO 32'h00000000

`endif

// ===== logic/device_capability_registers.v
/*
  Read-only device capability register bank on an APB slave port, plus
  the masking of the run, sleep and deep-sleep clock gating words by the
  capability bits, with the sample-rate setting clipped to the maximum.
  Assumes an APB master on i_ref_clk and a synchronous active-high reset.
*/
// Our own choice: the APB slave port.
`include "capability_defines.vh"

module device_capability_registers #(
  parameter ADDR_W = 12
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output wire o_pslverr,
  output wire [31:0] o_prdata,
  input wire [31:0] i_run_clock_gating_word,
  input wire [31:0] i_sleep_clock_gating_word,
  input wire [31:0] i_deep_sleep_clock_gating_word,
  output wire [31:0] o_run_clock_gating_word,
  output wire [31:0] o_sleep_clock_gating_word,
  output wire [31:0] o_deep_sleep_clock_gating_word
);

  // ****************************************
  // Hard-wired capability words
  // ****************************************
  // Reserved bits are tied to zero so reads are stable.
  wire [31:0] memory_size_caps;
  wire [31:0] core_feature_caps;
  wire [31:0] peripheral_presence_caps;

  assign memory_size_caps = {`RAM_SIZE_CODE, `PROGRAM_MEMORY_SIZE_CODE};

  function [31:0] set_bit;
    input [31:0] word;
    input integer pos;
    begin
      set_bit = word | (32'h00000001 << pos);
    end
  endfunction

  assign core_feature_caps =
    set_bit(set_bit(set_bit(set_bit(set_bit(set_bit(set_bit(set_bit(set_bit(
      {16'h0000, `MIN_SYSTEM_DIVIDER, `MAX_SAMPLE_RATE_CODE, 8'h00},
      `BIT_PWM),
      `BIT_ADC),
      `BIT_PROTECTION_UNIT),
      `BIT_TEMP_SENSOR),
      `BIT_SYNTHESIZER),
      `BIT_WATCHDOG),
      `BIT_TRACE_OUTPUT),
      `BIT_TWO_WIRE_DEBUG),
      `BIT_BOUNDARY_SCAN);

  assign peripheral_presence_caps =
    set_bit(set_bit(set_bit(set_bit(set_bit(set_bit(set_bit(set_bit(
      `WORD_ZERO,
      `BIT_COMPARATOR_ZERO),
      `BIT_TIMER_TWO),
      `BIT_TIMER_ONE),
      `BIT_TIMER_ZERO),
      `BIT_QUADRATURE_DECODER),
      `BIT_SYNC_SERIAL),
      `BIT_ASYNC_SERIAL_ONE),
      `BIT_ASYNC_SERIAL_ZERO);

  // ****************************************
  // Address decode
  // ****************************************
  // Returns 2'd0 for unmapped, else register number 1..3.
  function [1:0] decode_index;
    input [ADDR_W-1:0] addr;
    begin
      if (addr == `MEMORY_SIZE_CAPS_OFFSET) begin
        decode_index = 2'd1;
      end else if (addr == `CORE_FEATURE_CAPS_OFFSET) begin
        decode_index = 2'd2;
      end else if (addr == `PERIPHERAL_PRESENCE_CAPS_OFFSET) begin
        decode_index = 2'd3;
      end else begin
        decode_index = 2'd0;
      end
    end
  endfunction

  wire setup_phase;
  wire [1:0] addr_index;
  reg [31:0] read_word;

  assign setup_phase = i_psel & ~i_penable;
  assign addr_index = decode_index(i_paddr);

  always @* begin
    case (addr_index)
      2'd1: begin
        read_word = memory_size_caps;
      end
      2'd2: begin
        read_word = core_feature_caps;
      end
      2'd3: begin
        read_word = peripheral_presence_caps;
      end
      default: begin
        read_word = `WORD_ZERO;
      end
    endcase
  end

  // ****************************************
  // APB slave
  // ****************************************
  // Data is captured in the setup cycle so the access phase is zero-wait.
  // Writes never reach any storage; write data is deliberately unused.
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;
  reg slverr_q;
  reg slverr_d;

  always @* begin
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    if (setup_phase) begin
      slverr_d = (addr_index == 2'd0);
      if (i_pwrite) begin
        prdata_d = `WORD_ZERO;
      end else begin
        prdata_d = read_word;
      end
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      prdata_q <= `WORD_ZERO;
      slverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & slverr_q;
  assign o_prdata = prdata_q;

  // ****************************************
  // Clock gating masks
  // ****************************************
  function [31:0] mask_gating;
    input [31:0] word;
    input [31:0] caps;
    reg [3:0] rate;
    reg [3:0] limit;
    begin
      rate = word[`RATE_MSB:`RATE_LSB];
      limit = caps[`RATE_MSB:`RATE_LSB];
      mask_gating = word & caps & `GATE_SINGLE_BIT_MASK;
      if (rate > limit) begin
        mask_gating[`RATE_MSB:`RATE_LSB] = limit;
      end else begin
        mask_gating[`RATE_MSB:`RATE_LSB] = rate;
      end
    end
  endfunction

  reg [31:0] run_gate_q;
  reg [31:0] sleep_gate_q;
  reg [31:0] deep_gate_q;

  // One cycle of latency; outputs read zero (all gated off) in reset.
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      run_gate_q <= `WORD_ZERO;
      sleep_gate_q <= `WORD_ZERO;
      deep_gate_q <= `WORD_ZERO;
    end else begin
      run_gate_q <= mask_gating(i_run_clock_gating_word, core_feature_caps);
      sleep_gate_q <= mask_gating(i_sleep_clock_gating_word, core_feature_caps);
      deep_gate_q <= mask_gating(i_deep_sleep_clock_gating_word, core_feature_caps);
    end
  end

  assign o_run_clock_gating_word = run_gate_q;
  assign o_sleep_clock_gating_word = sleep_gate_q;
  assign o_deep_sleep_clock_gating_word = deep_gate_q;

endmodule

// ===== dv/capability_monitor.sv
/*
  Checker for the capability register bank: read words, error flag, gating masks.
  Assumes it is bound to the bank and sees only its ports.
*/
module capability_monitor #(parameter ADDR_W = 12) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [31:0] o_prdata,
  input wire [31:0] i_run_clock_gating_word,
  input wire [31:0] i_sleep_clock_gating_word,
  input wire [31:0] i_deep_sleep_clock_gating_word,
  input wire [31:0] o_run_clock_gating_word,
  input wire [31:0] o_sleep_clock_gating_word,
  input wire [31:0] o_deep_sleep_clock_gating_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Helpers
  // ****************************************
  function automatic [31:0] gate_f(input [31:0] w);
    gate_f = (w & 32'h0011000f) | {20'h0, ((w[11:8] > 4'h3) ? 4'h3 : w[11:8]), 8'h0};
  endfunction
  wire acc = i_psel && i_penable;
  wire rd = acc && !i_pwrite;
  wire mapped = (i_paddr == 'h004) || (i_paddr == 'h010) || (i_paddr == 'h014);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ****************************************
  // Assertions
  // ****************************************
  a_run_gate_mask: assert property (!$past(i_rst) |->
    o_run_clock_gating_word == gate_f($past(i_run_clock_gating_word))) else $error("run mask");
  a_sleep_gate_mask: assert property (!$past(i_rst) |->
    o_sleep_clock_gating_word == gate_f($past(i_sleep_clock_gating_word))) else $error("sleep");
  a_deep_gate_clip: assert property (!$past(i_rst) |->
    o_deep_sleep_clock_gating_word == gate_f($past(i_deep_sleep_clock_gating_word)))
    else $error("deep mask");
  a_mem_word_read: assert property (rd && i_paddr == 'h004 |-> o_prdata == 32'h001f001f)
    else $error("memory word");
  a_core_word_read: assert property (rd && i_paddr == 'h010 |->
    (o_prdata & 32'h0011ffbf) == 32'h001133bf) else $error("core word");
  a_periph_word_read: assert property (rd && i_paddr == 'h014 |->
    (o_prdata & 32'h01070113) == 32'h01070113) else $error("peripheral word");
  a_err_mapped_low: assert property (acc && mapped |-> !o_pslverr)
    else $error("error on mapped word");
  a_err_outside_access: assert property (!acc |-> !o_pslverr)
    else $error("error outside access");
  c_read_core: cover property (rd && i_paddr == 'h010);
  c_unmapped: cover property (acc && o_pslverr);
  c_rate_clip: cover property (i_run_clock_gating_word[11:8] > 4'h3);
endmodule

bind device_capability_registers capability_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_prdata(o_prdata),
  .i_run_clock_gating_word(i_run_clock_gating_word),
  .i_sleep_clock_gating_word(i_sleep_clock_gating_word),
  .i_deep_sleep_clock_gating_word(i_deep_sleep_clock_gating_word),
  .o_run_clock_gating_word(o_run_clock_gating_word),
  .o_sleep_clock_gating_word(o_sleep_clock_gating_word),
  .o_deep_sleep_clock_gating_word(o_deep_sleep_clock_gating_word));

// ===== dv/device_capability_registers_bench.sv
/*
  Self-checking bench for the capability register bank.
  Assumes the bank answers APB without wait states and masks gating words one cycle late.
*/
module device_capability_registers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, run_w = 32'h0, slp_w = 32'h0, dsl_w = 32'h0;
  logic pready, pslverr;
  logic [31:0] prdata, run_o, slp_o, dsl_o, rdv;
  logic errv;
  int n_fail = 0, tests_run = 0;
  always #25 clk = ~clk;
  device_capability_registers dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
    .i_run_clock_gating_word(run_w), .i_sleep_clock_gating_word(slp_w),
    .i_deep_sleep_clock_gating_word(dsl_w), .o_run_clock_gating_word(run_o),
    .o_sleep_clock_gating_word(slp_o), .o_deep_sleep_clock_gating_word(dsl_o));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) check_word(32'h0, 32'h1);
    rdv = prdata; errv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Reserved bits are masked off: they may read anything
  task automatic read_caps();
    apb(1'b0, 12'h004, 32'h0); check_word(rdv, 32'h001f001f);
    check_word({31'h0, errv}, 32'h0);
    apb(1'b0, 12'h010, 32'h0); check_word(rdv & 32'h0011ffbf, 32'h001133bf);
    apb(1'b0, 12'h014, 32'h0); check_word(rdv & 32'h01070113, 32'h01070113);
  endtask
  task automatic write_ignored();
    apb(1'b1, 12'h004, 32'hffffffff); check_word({31'h0, errv}, 32'h0);
    apb(1'b1, 12'h010, 32'h00000000);
    apb(1'b1, 12'h014, 32'hfefefefe);
    read_caps();
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    read_caps();
  endtask
  task automatic unmapped();
    apb(1'b0, 12'h008, 32'h0); check_word({31'h0, errv}, 32'h1);
    apb(1'b0, 12'h018, 32'h0); check_word({31'h0, errv}, 32'h1);
  endtask
  task automatic gating();
    logic [31:0] tbl [6] = '{32'hffffffff, 32'h0, 32'h00000200, 32'h00000300,
                             32'h00000f00, 32'hffeef0f0};
    logic [31:0] e;
    foreach (tbl[i]) begin
      @(posedge clk) run_w <= tbl[i];
      slp_w <= ~tbl[i]; dsl_w <= tbl[i] ^ 32'h00000400;
      repeat (2) @(posedge clk);
      e = (tbl[i] & 32'h0011000f) | {20'h0, (tbl[i][11:8] > 4'h3) ? 4'h3 : tbl[i][11:8], 8'h0};
      check_word(run_o, e);
      e = ~tbl[i];
      check_word(slp_o, (e & 32'h0011000f) | {20'h0, (e[11:8] > 4'h3) ? 4'h3 : e[11:8], 8'h0});
      e = tbl[i] ^ 32'h00000400;
      check_word(dsl_o, (e & 32'h0011000f) | {20'h0, (e[11:8] > 4'h3) ? 4'h3 : e[11:8], 8'h0});
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    read_caps();
    write_ignored();
    unmapped();
    gating();
    summarize();
  end
  // Far beyond the roughly 70 cycles the tests take
  initial begin
    #(50 * 5000);
    n_fail++;
    summarize();
  end
endmodule
